// file: design/rtf_delayed_clear.sv
// rtc flags register: one sticky flag whose user clear lands after a delay
// assumes set and clear requests are single-cycle pulses on the same clock
`timescale 1ns/1ps

module rtf_delayed_clear
	import rtf_pkg::*;
#(
	parameter int DELAY_CYC = RTC_FLAG_UPDATE_DELAY_CYC
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// requests
	input wire logic set_in, // hardware event, wins over any clear
	input wire logic clear_req_in, // user wrote zero to the flag
	// state
	output logic flag_out,
	output logic busy_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(DELAY_CYC + 1);

	typedef struct packed
	{
		logic flag; // stored flag value
		logic busy; // clear pending
		logic [CNT_W-1:0] cnt; // cycles left until the clear lands
	} rtf_dc_state_t;

	rtf_dc_state_t dc_r;
	rtf_dc_state_t dc_nxt;

	// next state: countdown, then clear; a set cancels it
	always_comb
	begin
		dc_nxt = dc_r;
		if (dc_r.busy)
		begin
			// clear lands only once the delay has run out
			if (dc_r.cnt <= CNT_W'(1))
			begin
				dc_nxt.flag = 1'b0;
				dc_nxt.busy = 1'b0;
			end
			else
			begin
				dc_nxt.cnt = dc_r.cnt - CNT_W'(1);
			end
		end
		else if (clear_req_in && dc_r.flag)
		begin
			// start the delay rather than clearing at once
			dc_nxt.busy = 1'b1;
			dc_nxt.cnt = CNT_W'(DELAY_CYC);
		end
		// an event in the same cycle must not be lost
		if (set_in)
		begin
			dc_nxt.flag = 1'b1;
			dc_nxt.busy = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			dc_r <= '0;
		else
			dc_r <= dc_nxt;
	end

	assign flag_out = dc_r.flag;
	assign busy_out = dc_r.busy;

endmodule

// file: design/rtf_flags_reg.sv
// rtc flags register: status flags plus calibration and hold controls
// assumes the serial-bus front end presents single-cycle read and write strobes
// with a register index; analog monitors arrive asynchronously on pins
`timescale 1ns/1ps

module rtf_flags_reg
	import rtf_pkg::*;
#(
	parameter int UPDATE_DELAY_CYC = RTC_FLAG_UPDATE_DELAY_CYC
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// register port from the serial-bus front end
	input wire logic wr_stb_in,
	input wire logic rd_stb_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// asynchronous monitor pins
	input wire logic backup_below_min_in,
	input wire logic osc_stopped_in,
	input wire logic power_below_switch_in,
	// same-clock events from the timekeeping logic
	input wire logic watchdog_expire_in,
	input wire logic alarm_match_in,
	// control and status outputs
	output logic [7:0] flags_out,
	output logic cal_output_en_out,
	output logic write_hold_out,
	output logic read_hold_out,
	output logic clear_pending_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		rtf_state_t state; // startup sequencer
		logic [1:0] settle_cnt; // synchroniser fill counter
		logic [2:0] bp_sync; // backup monitor synchroniser
		logic [2:0] osc_sync; // oscillator monitor synchroniser
		logic [2:0] pf_sync; // power monitor synchroniser
		logic bp_filt; // agreed backup level
		logic osc_filt; // agreed oscillator level
		logic pf_filt; // agreed power level
		logic pf_filt_d; // previous agreed power level
		logic watchdog_expired_flag;
		logic alarm_match_flag;
		logic power_fail_flag;
		logic cal_output; // calibration square wave enable
		logic write_hold;
		logic read_hold;
		logic [7:0] rd_data;
		logic rd_valid;
	} rtf_main_state_t;

	rtf_main_state_t st_r;
	rtf_main_state_t st_nxt;

	// decoded strobes and sub-flag hookups
	logic hit_flags; // index matches the flags register
	logic wr_hit; // write to the flags register
	logic rd_hit; // read of the flags register
	logic bpf_set; // backup fail event
	logic oscillator_fail_flag_set; // oscillator fail event
	logic bpf_clr_req; // host wrote zero to backup fail
	logic oscillator_fail_flag_clr_req; // host wrote zero to oscillator fail
	logic backup_power_fail_flag;
	logic oscillator_fail_flag;
	logic bpf_busy;
	logic oscillator_fail_flag_busy;
	logic [7:0] flags_now; // live register image

	assign hit_flags = (addr_in == FLAGS_OFFSET);
	assign wr_hit = wr_stb_in && hit_flags;
	assign rd_hit = rd_stb_in && hit_flags;

	// ----------------------------------------------------------------
	// register image
	// ----------------------------------------------------------------
	// field order is fixed by the register layout
	always_comb
	begin
		flags_now = FLAGS_RESET;
		flags_now[WATCHDOG_EXPIRED_BIT] = st_r.watchdog_expired_flag;
		flags_now[ALARM_MATCH_BIT] = st_r.alarm_match_flag;
		flags_now[POWER_FAIL_BIT] = st_r.power_fail_flag;
		flags_now[OSCILLATOR_FAIL_BIT] = oscillator_fail_flag;
		flags_now[BACKUP_POWER_FAIL_BIT] = backup_power_fail_flag;
		flags_now[CAL_OUTPUT_BIT] = st_r.cal_output;
		flags_now[WRITE_HOLD_BIT] = st_r.write_hold;
		flags_now[READ_HOLD_BIT] = st_r.read_hold;
	end

	// ----------------------------------------------------------------
	// sticky flags with delayed user clear
	// ----------------------------------------------------------------
	// backup monitor is only sampled once, at the end of startup settle;
	// the agreed level landing on that edge is used, the stored one is a cycle late
	assign bpf_set = (st_r.state == RTF_ST_SETTLE) && (st_r.settle_cnt == SYNC_SETTLE_CYC)
		&& st_nxt.bp_filt;
	// oscillator fail sets whenever the monitor reports it once startup settle is over
	assign oscillator_fail_flag_set = (st_r.state == RTF_ST_RUN) && st_r.osc_filt;
	// only a written zero clears; a written one cannot set these flags
	assign bpf_clr_req = wr_hit && !wr_data_in[BACKUP_POWER_FAIL_BIT];
	assign oscillator_fail_flag_clr_req = wr_hit && !wr_data_in[OSCILLATOR_FAIL_BIT];

	rtf_delayed_clear #(
		.DELAY_CYC(UPDATE_DELAY_CYC)
	) u_bpf (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.set_in(bpf_set),
		.clear_req_in(bpf_clr_req),
		.flag_out(backup_power_fail_flag),
		.busy_out(bpf_busy)
	);

	rtf_delayed_clear #(
		.DELAY_CYC(UPDATE_DELAY_CYC)
	) u_oscillator_fail_flag (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.set_in(oscillator_fail_flag_set),
		.clear_req_in(oscillator_fail_flag_clr_req),
		.flag_out(oscillator_fail_flag),
		.busy_out(oscillator_fail_flag_busy)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;

		// three-flop synchronisers; first stage feeds only the second
		st_nxt.bp_sync = {st_r.bp_sync[1:0], backup_below_min_in};
		st_nxt.osc_sync = {st_r.osc_sync[1:0], osc_stopped_in};
		st_nxt.pf_sync = {st_r.pf_sync[1:0], power_below_switch_in};
		// a change counts once stages two and three agree
		if (st_r.bp_sync[1] == st_r.bp_sync[2])
			st_nxt.bp_filt = st_r.bp_sync[2];
		if (st_r.osc_sync[1] == st_r.osc_sync[2])
			st_nxt.osc_filt = st_r.osc_sync[2];
		if (st_r.pf_sync[1] == st_r.pf_sync[2])
			st_nxt.pf_filt = st_r.pf_sync[2];
		st_nxt.pf_filt_d = st_r.pf_filt;

		// startup: let the synchronisers fill before trusting the monitor
		case (st_r.state)
			RTF_ST_SETTLE:
			begin
				if (st_r.settle_cnt == SYNC_SETTLE_CYC)
					st_nxt.state = RTF_ST_RUN;
				else
					st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
			end
			RTF_ST_RUN:
			begin
				st_nxt.state = RTF_ST_RUN; // stays until next power-up
			end
			default:
			begin
				st_nxt.state = RTF_ST_SETTLE;
			end
		endcase

		// read answer one cycle after the strobe; unmapped reads zero
		st_nxt.rd_valid = rd_stb_in;
		if (rd_stb_in)
			st_nxt.rd_data = hit_flags ? flags_now : UNMAPPED_READ;

		// read-to-clear flags; clear applies to the value just captured
		if (rd_hit)
		begin
			st_nxt.watchdog_expired_flag = 1'b0;
			st_nxt.alarm_match_flag = 1'b0;
			st_nxt.power_fail_flag = 1'b0;
		end
		// events override a same-cycle read clear
		if (watchdog_expire_in)
			st_nxt.watchdog_expired_flag = 1'b1;
		if (alarm_match_in)
			st_nxt.alarm_match_flag = 1'b1;
		// power fail is flagged on the falling crossing of the threshold
		if (st_r.pf_filt && !st_r.pf_filt_d)
			st_nxt.power_fail_flag = 1'b1;

		// host-writable control bits; the flag bits are not written here
		if (wr_hit)
		begin
			st_nxt.cal_output = wr_data_in[CAL_OUTPUT_BIT];
			st_nxt.write_hold = wr_data_in[WRITE_HOLD_BIT];
			st_nxt.read_hold = wr_data_in[READ_HOLD_BIT];
		end
	end

	// register the state; power-up clears everything
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data_out = st_r.rd_data;
	assign rd_valid_out = st_r.rd_valid;
	assign flags_out = flags_now;
	assign cal_output_en_out = st_r.cal_output;
	assign write_hold_out = st_r.write_hold;
	assign read_hold_out = st_r.read_hold;
	assign clear_pending_out = bpf_busy || oscillator_fail_flag_busy;

endmodule

// file: design/rtf_pkg.sv
// rtc flags register: shared constants, offsets, field positions, timing
// assumes a 10 MHz system clock; power-up reset is the synchronous system reset
package rtf_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // register index width from the serial front end
	localparam logic [ADDR_W-1:0] FLAGS_OFFSET = 8'h00; // rtc_flags_and_control
	localparam logic [7:0] FLAGS_RESET = 8'h00; // all flags and controls clear
	localparam logic [7:0] UNMAPPED_READ = 8'h00; // answer for other indices

	// ----------------------------------------------------------------
	// field positions, bit 7 down to bit 0
	// ----------------------------------------------------------------
	localparam int WATCHDOG_EXPIRED_BIT = 7;
	localparam int ALARM_MATCH_BIT = 6;
	localparam int POWER_FAIL_BIT = 5;
	localparam int OSCILLATOR_FAIL_BIT = 4;
	localparam int BACKUP_POWER_FAIL_BIT = 3;
	localparam int CAL_OUTPUT_BIT = 2;
	localparam int WRITE_HOLD_BIT = 1;
	localparam int READ_HOLD_BIT = 0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100; // 10 MHz
	localparam int RTC_FLAG_UPDATE_DELAY_NS = 1000; // plain default, least time
	// least time rounds up, never below one cycle
	localparam int RTC_FLAG_UPDATE_DELAY_RAW =
		(RTC_FLAG_UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTC_FLAG_UPDATE_DELAY_CYC =
		(RTC_FLAG_UPDATE_DELAY_RAW < 1) ? 1 : RTC_FLAG_UPDATE_DELAY_RAW;
	localparam logic [1:0] SYNC_SETTLE_CYC = 2'h3; // cycles before first pin sample

	// ----------------------------------------------------------------
	// startup sequencer
	// ----------------------------------------------------------------
	typedef enum logic [0:0]
	{
		RTF_ST_SETTLE = 1'b0, // waiting for synchronisers to fill
		RTF_ST_RUN = 1'b1 // normal operation
	} rtf_state_t;

endpackage

// file: tb/rtf_flags_checker.sv
// rtc flags register checker: port-level timing relations
// assumes it is bound to rtf_flags_reg and shares its clock and reset
`timescale 1ns/1ps
module rtf_flags_checker
	import rtf_pkg::*;
#(
	parameter int UPDATE_DELAY_CYC = RTC_FLAG_UPDATE_DELAY_CYC
)
(
	// watched design ports
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic wr_stb_in,
	input wire logic rd_stb_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic backup_below_min_in,
	input wire logic watchdog_expire_in,
	input wire logic alarm_match_in,
	input wire logic [7:0] flags_out,
	input wire logic cal_output_en_out,
	input wire logic clear_pending_out
);
	// last cycle of a pending clear, counted from its first
	localparam int DM1 = UPDATE_DELAY_CYC - 1;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_reset_clears_all: assert property ($fell(sys_rst_in) |-> flags_out == 8'h00 && !rd_valid_out)
		else $error("flags not clear after reset");
	// answer pulse mirrors the strobe one cycle later, never more, never less
	a_read_answer: assert property (rd_valid_out == $past(rd_stb_in))
		else $error("read not answered next cycle");
	a_unmapped_read: assert property (rd_stb_in && addr_in != 8'h00 |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	a_bp_from_pin: assert property ($rose(flags_out[3]) |-> $past(backup_below_min_in))
		else $error("backup fail flag set without failed backup");
	a_bp_sticky: assert property ($fell(flags_out[3]) |-> $past(clear_pending_out))
		else $error("backup fail flag cleared on its own");
	a_clear_waits: assert property (wr_stb_in && addr_in == 8'h00 && !wr_data_in[3]
		&& flags_out[3] && !clear_pending_out |=> clear_pending_out && flags_out[3])
		else $error("backup fail clear not delayed");
	a_clear_delay: assert property ($rose(clear_pending_out) |-> ##DM1 clear_pending_out
		##1 !clear_pending_out)
		else $error("clear delay length wrong");
	a_osc_delayed: assert property ($fell(flags_out[4]) |-> $past(clear_pending_out))
		else $error("oscillator fail flag cleared without delay");
	a_events_set: assert property (watchdog_expire_in && alarm_match_in |=> flags_out[7:6] == 2'h3)
		else $error("event bits not set");
	a_ctrl_write: assert property (wr_stb_in && addr_in == 8'h00 |=>
		flags_out[2:0] == $past(wr_data_in[2:0]) && cal_output_en_out == flags_out[2])
		else $error("control bits not written");
	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	c_clear: cover property ($fell(clear_pending_out));
	c_read: cover property (rd_valid_out && rd_data_out[7]);
	c_bp: cover property ($rose(flags_out[3]));
endmodule

// file: tb/rtf_flags_reg_test.sv
// rtc flags register testbench: table of register cases then event tests
// assumes a short clear delay of two cycles
`timescale 1ns/1ps
module rtf_flags_reg_test;
	import rtf_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rtf_row_t;
	localparam int DLY = 2;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic wr_stb, rd_stb, rd_valid, bp = 1'b1, osc = 1'b0, pwr = 1'b0, wd = 1'b0, al = 1'b0;
	logic cal, wh, rh, pend;
	logic [7:0] addr, wdata, rdata, flags, got;
	bit ok;
	int mismatches = 0;
	int checked = 0;
	// rows keep bit 3 written as one: a zero there would start the backup clear
	rtf_row_t rows[5] = '{'{8'h00, 8'h0F, 8'h0F}, '{8'h00, 8'hF8, 8'h08},
		'{8'h00, 8'h0D, 8'h0D}, '{8'h01, 8'hFF, 8'h00}, '{8'h00, 8'h0A, 8'h0A}};
	always #50 clk_in = ~clk_in;
	rtf_host_model rtf_host_model_i (.clk_in(clk_in), .rd_data_in(rdata),
		.rd_valid_in(rd_valid), .wr_stb_out(wr_stb), .rd_stb_out(rd_stb),
		.addr_out(addr), .wr_data_out(wdata));
	rtf_flags_reg #(.UPDATE_DELAY_CYC(DLY)) rtf_flags_reg_i (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb), .addr_in(addr),
		.wr_data_in(wdata), .rd_data_out(rdata), .rd_valid_out(rd_valid),
		.backup_below_min_in(bp), .osc_stopped_in(osc), .power_below_switch_in(pwr),
		.watchdog_expire_in(wd), .alarm_match_in(al), .flags_out(flags),
		.cal_output_en_out(cal), .write_hold_out(wh), .read_hold_out(rh),
		.clear_pending_out(pend));
	task automatic complete_run();
		$display("counts: checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic check_bit(input logic g, input logic e);
		check_byte({7'h00, g}, {7'h00, e});
	endtask
	// bounded wait for a flag bit
	task automatic wait_flag(input int i);
		for (int n = 0; n < 20 && flags[i] !== 1'b1; n++)
			@(negedge clk_in);
		if (flags[i] !== 1'b1)
		begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rtf_host_model_i.read_reg(a, got, ok);
		check_bit(ok, 1'b1);
		check_byte(got, e);
	endtask
	initial
	begin
		repeat (5) @(negedge clk_in);
		sys_rst_in = 1'b0;
		wait_flag(3);
		$display("test startup done");
		foreach (rows[k])
		begin
			rtf_host_model_i.write_reg(rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e);
		end
		check_byte({5'h00, cal, wh, rh}, 8'h02);
		$display("test table done");
		wd = 1'b1;
		al = 1'b1;
		@(negedge clk_in);
		wd = 1'b0;
		al = 1'b0;
		pwr = 1'b1;
		wait_flag(5);
		pwr = 1'b0;
		rd(8'h00, 8'hEA);
		rd(8'h00, 8'h0A);
		osc = 1'b1;
		wait_flag(4);
		osc = 1'b0;
		repeat (5) @(negedge clk_in);
		rd(8'h00, 8'h1A);
		$display("test events done");
		rtf_host_model_i.write_reg(8'h00, 8'h00);
		check_bit(pend, 1'b1);
		check_byte(flags, 8'h18);
		@(negedge clk_in);
		check_byte(flags, 8'h18);
		@(negedge clk_in);
		check_byte(flags, 8'h00);
		check_bit(pend, 1'b0);
		$display("test delayed clear done");
		sys_rst_in = 1'b1;
		bp = 1'b0;
		repeat (5) @(negedge clk_in);
		sys_rst_in = 1'b0;
		repeat (10) @(negedge clk_in);
		check_byte(flags, 8'h00);
		$display("test good backup done");
		complete_run();
	end
endmodule
bind rtf_flags_reg rtf_flags_checker #(.UPDATE_DELAY_CYC(UPDATE_DELAY_CYC)) rtf_flags_checker_i (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in),
	.addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
	.rd_valid_out(rd_valid_out), .backup_below_min_in(backup_below_min_in),
	.watchdog_expire_in(watchdog_expire_in), .alarm_match_in(alarm_match_in),
	.flags_out(flags_out), .cal_output_en_out(cal_output_en_out),
	.clear_pending_out(clear_pending_out));

// file: tb/rtf_host_model.sv
// rtc flags register: host side of the register strobe port
// assumes inputs change at the falling edge, design samples on the rising edge
`timescale 1ns/1ps
module rtf_host_model
	import rtf_pkg::*;
(
	// clock and answer
	input wire logic clk_in,
	input wire logic [7:0] rd_data_in,
	input wire logic rd_valid_in,
	// requests
	output logic wr_stb_out,
	output logic rd_stb_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic [7:0] wr_data_out
);
	initial
	begin
		wr_stb_out = 1'b0;
		rd_stb_out = 1'b0;
		addr_out = 8'h00;
		wr_data_out = 8'h00;
	end
	// one-cycle write; released lines show inverse so stale values never pass
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		wr_stb_out = 1'b1;
		addr_out = a;
		wr_data_out = d;
		@(negedge clk_in);
		wr_stb_out = 1'b0;
		addr_out = ~a;
		wr_data_out = ~d;
	endtask
	// one-cycle read; answer is sampled where it stands
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
		@(negedge clk_in);
		rd_stb_out = 1'b1;
		addr_out = a;
		@(negedge clk_in);
		rd_stb_out = 1'b0;
		addr_out = ~a;
		ok = rd_valid_in === 1'b1;
		d = rd_data_in;
	endtask
endmodule
